// file: hdl/irq_pkg.sv
// constants and helpers for the interrupt arbiter and power control block
// Functional notes
// - primary priority bits: 5 timer2, 4 serial1, 3 timer1, 2 ext1, 1 timer0, 0 ext0
// - secondary priority bits: 7 display channel, 4 serial2, 1 two-wire, 0 usb
// - flags sampled once per machine cycle at a fixed phase, polled next cycle
// - a sampled set flag produces a hardware vector call unless blocked
// - no call while equal or higher level routine is in progress
// - call only in the last machine cycle of the current instruction
// - no call during interrupt return or access to priority/enable registers
// - blocked requests are not remembered; each poll uses fresh samples only
// - call pushes program counter only, then loads the source vector
// - vectors 0003h,000Bh,0013h,001Bh,0023h,002Bh,0033h,003Bh,0043h,004Bh per source
// - interrupt return clears current in-progress level and pops program counter
// - plain return leaves in-progress state set
// - idle halts cpu only; peripherals keep running, pins keep data
// - idle ends on a taken interrupt or reset
// - power-down stops clock, keeps state, disables pwm, two-wire, display, usb
// - power-down ends only through reset
// - modes entered only by power control writes; power control resets to 00
// - power control bit 1 enters power-down, bit 0 enters idle
// - power control bits 7 and 6 double first and second serial baud
// - bit 5 disables low-volt reset, bit 4 adc irq, bits 3/2 serial2 clocks
// - priority bit 0 means low, 1 means high
// - equal level ties resolved by fixed polling order
// - high preempts low, high is never preempted, high wins simultaneous
// - taken interrupt clears idle bit; execution resumes after idle write
package irq_pkg;
    localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
    localparam logic [7:0] ADDR_PRIO1 = 8'hb8;
    localparam logic [7:0] ADDR_PRIO2 = 8'hb7;
    localparam logic [7:0] ADDR_EN1 = 8'ha8;
    localparam logic [7:0] ADDR_EN2 = 8'ha7;
    localparam logic [7:0] RST_POWER_CONTROL = 8'h00;
    localparam logic [7:0] RST_PRIO = 8'h00;
    localparam logic [7:0] MASK_PRIO1 = 8'h3f;
    localparam logic [7:0] MASK_PRIO2 = 8'h93;
    localparam int B_BAUD1 = 7;
    localparam int B_BAUD2 = 6;
    localparam int B_LVR_DIS = 5;
    localparam int B_ADC_IRQ = 4;
    localparam int B_RX_SEL2 = 3;
    localparam int B_TX_SEL2 = 2;
    localparam int B_PD = 1;
    localparam int B_IDLE = 0;
    localparam int N_SRC = 10;
    localparam logic [3:0] PHASES = 4'hc;
    // state 5 phase 2 of six two-phase states
    localparam logic [3:0] SAMPLE_PHASE = 4'h9;
    localparam logic [3:0] POLL_PHASE = 4'h3;

    // sources indexed in polling order, 0 first
    function automatic logic [15:0] vector_of(input logic [3:0] idx);
        unique case (idx)
            4'h0: vector_of = 16'h0003;
            4'h1: vector_of = 16'h004b;
            4'h2: vector_of = 16'h000b;
            4'h3: vector_of = 16'h0043;
            4'h4: vector_of = 16'h0013;
            4'h5: vector_of = 16'h003b;
            4'h6: vector_of = 16'h001b;
            4'h7: vector_of = 16'h0033;
            4'h8: vector_of = 16'h0023;
            4'h9: vector_of = 16'h002b;
            default: vector_of = 16'h0000;
        endcase
    endfunction : vector_of

    // priority bits into polling order
    function automatic logic [9:0] prio_order(input logic [7:0] p1, input logic [7:0] p2);
        prio_order = {p1[5], p1[4], p2[0], p1[3], p2[7], p1[2], p2[1], p1[1], p2[4], p1[0]};
    endfunction : prio_order
endpackage : irq_pkg

// file: hdl/irq_select.sv
// fixed-order arbiter picking the winning request of the upper level first
`timescale 1ns/1ps
module irq_select #(
    parameter int N = 10
) (
    input wire logic [N-1:0] req,
    input wire logic [N-1:0] level_high,
    output logic valid,
    output logic high,
    output logic [3:0] idx
);
    logic [N-1:0] req_high;

    function automatic logic [3:0] first_set(input logic [N-1:0] v);
        first_set = 4'h0;
        for (int i = N - 1; i >= 0; i--) begin
            if (v[i]) begin
                first_set = 4'(i);
            end
        end
    endfunction : first_set

    always_comb begin
        req_high = req & level_high;
        valid = |req;
        high = |req_high;
        if (high) begin
            idx = first_set(req_high);
        end else begin
            idx = first_set(req);
        end
    end
endmodule : irq_select

// file: hdl/irq_priority_vector_power_ctrl.sv
// interrupt polling, priority, vector call and power mode control
`timescale 1ns/1ps
module irq_priority_vector_power_ctrl #(
    parameter int N_SRC = 10
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic [N_SRC-1:0] irq_req,
    input wire logic last_cycle,
    input wire logic interrupt_return_instr,
    input wire logic plain_return_instr,
    output logic [3:0] mc_phase,
    output logic hardware_vector_call,
    output logic [15:0] vec_addr,
    output logic [3:0] vec_src,
    output logic stack_pop,
    output logic inprog_high,
    output logic inprog_low,
    output logic cpu_halt,
    output logic sys_clock_stop,
    output logic periph_disable,
    output logic baud_double_first,
    output logic baud_double_second,
    output logic lowvolt_reset_disable,
    output logic adc_irq_enable,
    output logic rx_clock_select_second,
    output logic tx_clock_select_second
);
    logic [3:0] phase_reg, phase_next;
    logic [N_SRC-1:0] sample_reg, sample_next;
    logic touch_reg, touch_next;
    logic [7:0] power_control_reg, power_control_next;
    logic [7:0] prio1_reg, prio1_next;
    logic [7:0] prio2_reg, prio2_next;
    logic [7:0] rdata_reg, rdata_next;
    logic hi_reg, hi_next;
    logic lo_reg, lo_next;
    logic call_reg, call_next;
    logic pop_reg, pop_next;
    logic [15:0] vec_reg, vec_next;
    logic [3:0] src_reg, src_next;
    logic sel_valid, sel_high;
    logic [3:0] sel_idx;
    logic poll, touching, level_block, take, interrupt_return_instr_done, ret_done;

    // the enable registers live elsewhere, but touching them must still hold off a call
    function automatic logic watched_addr(input logic [7:0] a);
        watched_addr = (a == irq_pkg::ADDR_PRIO1) || (a == irq_pkg::ADDR_PRIO2)
            || (a == irq_pkg::ADDR_EN1) || (a == irq_pkg::ADDR_EN2);
    endfunction : watched_addr

    irq_select #(.N(N_SRC)) u_sel (
        .req(sample_reg),
        .level_high(irq_pkg::prio_order(prio1_reg, prio2_reg)),
        .valid(sel_valid),
        .high(sel_high),
        .idx(sel_idx)
    );

    // machine cycle timing; the phase counter freezes while the clock is stopped
    always_comb begin
        phase_next = phase_reg;
        sample_next = sample_reg;
        if (!power_control_reg[irq_pkg::B_PD]) begin
            if (phase_reg == irq_pkg::PHASES - 4'h1) begin
                phase_next = 4'h0;
            end else begin
                phase_next = phase_reg + 4'h1;
            end
            if (phase_reg == irq_pkg::SAMPLE_PHASE) begin
                sample_next = irq_req;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            phase_reg <= 4'h0;
            sample_reg <= '0;
        end else begin
            phase_reg <= phase_next;
            sample_reg <= sample_next;
        end
    end

    // special function register port
    always_comb begin
        touching = (sfr_wr || sfr_rd) && watched_addr(sfr_addr);
        touch_next = touch_reg;
        if (phase_reg == irq_pkg::PHASES - 4'h1) begin
            touch_next = 1'b0;
        end
        if (touching) begin
            touch_next = 1'b1;
        end
        power_control_next = power_control_reg;
        prio1_next = prio1_reg;
        prio2_next = prio2_reg;
        rdata_next = rdata_reg;
        // with the clock stopped no write may alter a register until reset
        if (sfr_wr && !power_control_reg[irq_pkg::B_PD]) begin
            unique case (sfr_addr)
                irq_pkg::ADDR_POWER_CONTROL: begin
                    power_control_next = sfr_wdata;
                    // power-down is never left by a write
                    power_control_next[irq_pkg::B_PD] = power_control_reg[irq_pkg::B_PD] | sfr_wdata[irq_pkg::B_PD];
                    if (power_control_next[irq_pkg::B_PD]) begin
                        power_control_next[irq_pkg::B_IDLE] = 1'b0;
                    end
                end
                irq_pkg::ADDR_PRIO1: prio1_next = sfr_wdata & irq_pkg::MASK_PRIO1;
                irq_pkg::ADDR_PRIO2: prio2_next = sfr_wdata & irq_pkg::MASK_PRIO2;
                default: ;
            endcase
        end
        if (take) begin
            power_control_next[irq_pkg::B_IDLE] = 1'b0;
        end
        if (sfr_rd) begin
            unique case (sfr_addr)
                irq_pkg::ADDR_POWER_CONTROL: rdata_next = power_control_reg;
                irq_pkg::ADDR_PRIO1: rdata_next = prio1_reg;
                irq_pkg::ADDR_PRIO2: rdata_next = prio2_reg;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            touch_reg <= 1'b0;
            power_control_reg <= irq_pkg::RST_POWER_CONTROL;
            prio1_reg <= irq_pkg::RST_PRIO;
            prio2_reg <= irq_pkg::RST_PRIO;
            rdata_reg <= 8'h00;
        end else begin
            touch_reg <= touch_next;
            power_control_reg <= power_control_next;
            prio1_reg <= prio1_next;
            prio2_reg <= prio2_next;
            rdata_reg <= rdata_next;
        end
    end

    // polling and the in-progress levels
    always_comb begin
        poll = (phase_reg == irq_pkg::POLL_PHASE) && !power_control_reg[irq_pkg::B_PD];
        level_block = hi_reg || (lo_reg && !sel_high);
        take = poll && sel_valid && !level_block
            && last_cycle
            && !interrupt_return_instr && !touch_reg && !touching;
        interrupt_return_instr_done = poll && last_cycle && interrupt_return_instr;
        ret_done = poll && last_cycle && plain_return_instr;
        hi_next = hi_reg;
        lo_next = lo_reg;
        call_next = take;
        pop_next = interrupt_return_instr_done || ret_done;
        vec_next = vec_reg;
        src_next = src_reg;
        if (take) begin
            // only the return address goes on the stack, status is left alone
            vec_next = irq_pkg::vector_of(sel_idx);
            src_next = sel_idx;
            if (sel_high) begin
                hi_next = 1'b1;
            end else begin
                lo_next = 1'b1;
            end
        end
        if (interrupt_return_instr_done) begin
            if (hi_reg) begin
                hi_next = 1'b0;
            end else begin
                lo_next = 1'b0;
            end
        end
        // a plain return pops the counter but keeps the level busy
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            hi_reg <= 1'b0;
            lo_reg <= 1'b0;
            call_reg <= 1'b0;
            pop_reg <= 1'b0;
            vec_reg <= 16'h0000;
            src_reg <= 4'h0;
        end else begin
            hi_reg <= hi_next;
            lo_reg <= lo_next;
            call_reg <= call_next;
            pop_reg <= pop_next;
            vec_reg <= vec_next;
            src_reg <= src_next;
        end
    end

    assign sfr_rdata = rdata_reg;
    assign mc_phase = phase_reg;
    assign hardware_vector_call = call_reg;
    assign vec_addr = vec_reg;
    assign vec_src = src_reg;
    assign stack_pop = pop_reg;
    assign inprog_high = hi_reg;
    assign inprog_low = lo_reg;
    // idle stops only the cpu; peripherals see no halt
    assign cpu_halt = power_control_reg[irq_pkg::B_IDLE] | power_control_reg[irq_pkg::B_PD];
    assign sys_clock_stop = power_control_reg[irq_pkg::B_PD];
    assign periph_disable = power_control_reg[irq_pkg::B_PD];
    assign baud_double_first = power_control_reg[irq_pkg::B_BAUD1];
    assign baud_double_second = power_control_reg[irq_pkg::B_BAUD2];
    assign lowvolt_reset_disable = power_control_reg[irq_pkg::B_LVR_DIS];
    assign adc_irq_enable = power_control_reg[irq_pkg::B_ADC_IRQ];
    assign rx_clock_select_second = power_control_reg[irq_pkg::B_RX_SEL2];
    assign tx_clock_select_second = power_control_reg[irq_pkg::B_TX_SEL2];

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    sequence s_power_control_both;
        sfr_wr && sfr_addr == irq_pkg::ADDR_POWER_CONTROL && sfr_wdata[1:0] == 2'b11;
    endsequence
    sequence s_plain_ret;
        poll && last_cycle && plain_return_instr && !interrupt_return_instr;
    endsequence
    sequence s_interrupt_return_instr_high;
        interrupt_return_instr_done && hi_reg;
    endsequence
    sequence s_free_poll;
        poll && last_cycle && sel_valid && !hi_reg && !lo_reg && !interrupt_return_instr && !touch_reg && !touching;
    endsequence
    sequence s_prio1_wr;
        sfr_wr && sfr_addr == irq_pkg::ADDR_PRIO1 && !power_control_reg[1];
    endsequence

    a_sample_phase: assert property (!$stable(sample_reg) |-> $past(phase_reg) == 4'h9)
        else $error("samples changed outside sample phase");
    a_call_last_cyc: assert property (hardware_vector_call |-> $past(last_cycle) && $past(phase_reg) == 4'h3)
        else $error("call outside last cycle poll");
    a_call_no_interrupt_return_instr: assert property (hardware_vector_call |-> !$past(interrupt_return_instr) && !$past(touch_reg))
        else $error("call during return or priority access");
    a_high_blocks: assert property (hi_reg && !interrupt_return_instr_done |=> !hardware_vector_call)
        else $error("call while high level in progress");
    a_low_preempt: assert property (hardware_vector_call && $past(lo_reg) |-> $past(sel_high) && hi_reg)
        else $error("low routine preempted by low request");
    a_vector_val: assert property (hardware_vector_call |-> vec_addr == irq_pkg::vector_of(vec_src))
        else $error("vector does not match source");
    a_idle_cleared: assert property (hardware_vector_call |-> !power_control_reg[0])
        else $error("idle still set after call");
    a_pd_sticky: assert property (power_control_reg[1] |=> power_control_reg[1] && !hardware_vector_call)
        else $error("power-down left without reset");
    a_pd_wins: assert property (s_power_control_both |=> power_control_reg[1:0] == 2'b10)
        else $error("idle kept beside power-down");
    a_interrupt_return_instr_clear: assert property (s_interrupt_return_instr_high |=> !hi_reg && stack_pop)
        else $error("return did not clear high level");
    a_ret_keeps: assert property (s_plain_ret |=> (hi_reg || !$past(hi_reg)) && (lo_reg || !$past(lo_reg)))
        else $error("plain return cleared in-progress");
    a_one_per_mc: assert property (hardware_vector_call |=> !hardware_vector_call [*8])
        else $error("two calls in one machine cycle");

    // polling decisions
    a_free_poll_call: assert property (s_free_poll |=> hardware_vector_call && vec_src == $past(sel_idx))
        else $error("unblocked request not called");
    a_no_latch: assert property (hardware_vector_call |-> |(($past(sample_reg) >> vec_src) & N_SRC'(1)))
        else $error("call source absent from fresh samples");
    a_low_blocks: assert property (lo_reg && !sel_high && !interrupt_return_instr_done |=> !hardware_vector_call)
        else $error("low request called over low routine");
    a_touch_blocks: assert property (touching |=> !hardware_vector_call)
        else $error("call during priority or enable access");
    a_call_level: assert property (hardware_vector_call |-> (hi_reg && !$past(hi_reg))
        || (lo_reg && !$past(lo_reg)))
        else $error("call did not mark a new level");
    a_vec_holds: assert property (!hardware_vector_call |-> $stable({vec_addr, vec_src}))
        else $error("vector moved without a call");
    a_interrupt_return_instr_low: assert property (interrupt_return_instr_done && !hi_reg && lo_reg |=> !lo_reg && stack_pop)
        else $error("return did not clear low level");
    a_pop_cause: assert property (stack_pop |-> $past(interrupt_return_instr_done) || $past(ret_done))
        else $error("pop without a return");

    // registers and power modes
    a_prio1_rsvd: assert property (prio1_reg[7:6] == 2'b00)
        else $error("reserved primary priority bits set");
    a_prio2_unused: assert property ((prio2_reg & ~irq_pkg::MASK_PRIO2) == 8'h00)
        else $error("unused secondary priority bits set");
    a_prio_write: assert property (s_prio1_wr |=> prio1_reg == ($past(sfr_wdata) & irq_pkg::MASK_PRIO1))
        else $error("primary priority write lost");
    a_read_back: assert property (sfr_rd && sfr_addr == irq_pkg::ADDR_POWER_CONTROL |=> sfr_rdata == $past(power_control_reg))
        else $error("power control read wrong");
    a_idle_enter: assert property ($rose(power_control_reg[0]) |-> $past(sfr_wr)
        && $past(sfr_addr) == irq_pkg::ADDR_POWER_CONTROL)
        else $error("idle set without a write");
    a_pd_enter: assert property ($rose(power_control_reg[1]) |-> $past(sfr_wr) && $past(sfr_wdata[1]))
        else $error("power-down set without a write");
    a_idle_exit: assert property ($fell(power_control_reg[0]) |-> hardware_vector_call || $past(sfr_wr))
        else $error("idle left without call or write");
    a_idle_halt: assert property (power_control_reg[0] |-> cpu_halt && !periph_disable && !sys_clock_stop)
        else $error("idle stopped more than the cpu");
    a_pd_outputs: assert property (power_control_reg[1] |-> cpu_halt && sys_clock_stop && periph_disable)
        else $error("power-down outputs not asserted");
    a_pd_freeze: assert property (power_control_reg[1] |=> $stable({phase_reg, sample_reg}))
        else $error("timing moved while clock stopped");
    a_pd_no_write: assert property (power_control_reg[1] |=> $stable({power_control_reg, prio1_reg, prio2_reg}))
        else $error("register changed in power-down");
endmodule : irq_priority_vector_power_ctrl

// file: verif/cpu_core_model.sv
// behavioural cpu core facing the interrupt block: instruction status and stack depth
`timescale 1ns/1ps
module cpu_core_model (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic hardware_vector_call,
    input wire logic stack_pop,
    input wire logic [1:0] ret_kind,
    input wire logic mid_instr,
    output logic last_cycle,
    output logic interrupt_return_instr,
    output logic plain_return_instr,
    output logic [7:0] stack_depth
);
    logic [7:0] depth_next;
    assign last_cycle = !mid_instr;
    assign interrupt_return_instr = (ret_kind == 2'h1);
    assign plain_return_instr = (ret_kind == 2'h2);
    // a call stacks only the two program counter bytes, never the status word
    always_comb begin
        depth_next = stack_depth;
        if (hardware_vector_call) begin
            depth_next = stack_depth + 8'h02;
        end else if (stack_pop) begin
            depth_next = stack_depth - 8'h02;
        end
    end
    always_ff @(posedge clk_sys) begin
        stack_depth <= srst ? 8'h00 : depth_next;
    end
endmodule : cpu_core_model

// file: verif/tb_irq_priority_vector_power_ctrl.sv
// self-checking bench for the interrupt arbiter and power control block
`timescale 1ns/1ps
module tb_irq_priority_vector_power_ctrl;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, stack_depth;
    logic sfr_wr, sfr_rd, last_cycle, interrupt_return_instr, plain_return_instr, mid_instr;
    logic hardware_vector_call, stack_pop, inprog_high, inprog_low, cpu_halt, sys_clock_stop, periph_disable;
    logic baud_double_first, baud_double_second, lowvolt_reset_disable, adc_irq_enable;
    logic rx_clock_select_second, tx_clock_select_second;
    logic [9:0] irq_req;
    logic [1:0] ret_kind;
    logic [3:0] mc_phase, vec_src;
    logic [15:0] vec_addr;
    logic [15:0] vtab [10] = '{16'h0003, 16'h004b, 16'h000b, 16'h0043, 16'h0013,
                               16'h003b, 16'h001b, 16'h0033, 16'h0023, 16'h002b};
    int miscompares = 0;
    int checks = 0;

    irq_priority_vector_power_ctrl #(.N_SRC(10)) u_dut (.clk_sys, .srst, .sfr_addr, .sfr_wr, .sfr_rd,
        .sfr_wdata, .sfr_rdata, .irq_req, .last_cycle, .interrupt_return_instr, .plain_return_instr,
        .mc_phase, .hardware_vector_call, .vec_addr, .vec_src, .stack_pop, .inprog_high, .inprog_low,
        .cpu_halt, .sys_clock_stop, .periph_disable, .baud_double_first, .baud_double_second,
        .lowvolt_reset_disable, .adc_irq_enable, .rx_clock_select_second, .tx_clock_select_second);
    cpu_core_model u_model (.clk_sys, .srst, .hardware_vector_call, .stack_pop, .ret_kind, .mid_instr,
        .last_cycle, .interrupt_return_instr, .plain_return_instr, .stack_depth);

    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic close_out();
        if (miscompares == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // inputs always move 1 ns after the rising edge
    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        tick();
        sfr_wr = 1'b0;
        // one quiet edge so a following call never flips a strobe in the same step
        tick();
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        sfr_addr = a;
        sfr_rd = 1'b1;
        tick();
        sfr_rd = 1'b0;
        chk("sfr_rdata", {8'h00, e}, {8'h00, sfr_rdata});
        tick();
    endtask : rd

    // bounded: a frozen phase counter must not hang the run
    task automatic wait_ph(input logic [3:0] p);
        for (int n = 0; n < 30 && mc_phase !== p; n++) begin
            tick();
        end
        if (mc_phase !== p) begin
            miscompares++;
            close_out();
        end
    endtask : wait_ph

    // request held across the sample phase only, then judged one cycle after the poll edge
    task automatic poll(input logic [9:0] req, input logic call, input logic [3:0] src);
        wait_ph(4'h4);
        irq_req = req;
        wait_ph(4'ha);
        irq_req = 10'h000;
        wait_ph(4'h3);
        tick();
        chk("vector_call", {15'h0000, call}, {15'h0000, hardware_vector_call});
        if (call) begin
            chk("vec_src", {12'h000, src}, {12'h000, vec_src});
            chk("vec_addr", vtab[src], vec_addr);
        end
    endtask : poll

    task automatic ret(input logic [1:0] kind, input logic [9:0] req);
        wait_ph(4'h4);
        ret_kind = kind;
        irq_req = req;
        wait_ph(4'h3);
        tick();
        chk("stack_pop", 16'h0001, {15'h0000, stack_pop});
        chk("vector_call", 16'h0000, {15'h0000, hardware_vector_call});
        ret_kind = 2'h0;
        irq_req = 10'h000;
    endtask : ret

    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        close_out();
    end

    initial begin
        {sfr_addr, sfr_wdata, sfr_wr, sfr_rd, irq_req, ret_kind, mid_instr} = '0;
        repeat (4) tick();
        srst = 1'b0;
        rd(8'h87, 8'h00);
        rd(8'hb8, 8'h00);
        rd(8'hb7, 8'h00);
        chk("cpu_halt", 16'h0000, {15'h0000, cpu_halt});
        wr(8'hb8, 8'hff);
        rd(8'hb8, 8'h3f);
        wr(8'hb7, 8'hff);
        rd(8'hb7, 8'h93);
        rd(8'h55, 8'h00);
        wr(8'hb8, 8'h00);
        wr(8'hb7, 8'h00);
        for (int i = 0; i < 10; i++) begin
            poll(10'h3ff << i, 1'b1, i[3:0]);
            chk("inprog_low", 16'h0001, {15'h0000, inprog_low});
            ret(2'h1, 10'h000);
            chk("inprog_low", 16'h0000, {15'h0000, inprog_low});
        end
        wr(8'hb8, 8'h20);
        poll(10'h3ff, 1'b1, 4'h9);
        chk("inprog_high", 16'h0001, {15'h0000, inprog_high});
        poll(10'h001, 1'b0, 4'h0);
        ret(2'h1, 10'h001);
        chk("inprog_high", 16'h0000, {15'h0000, inprog_high});
        poll(10'h001, 1'b1, 4'h0);
        poll(10'h200, 1'b1, 4'h9);
        tick();
        chk("stack_depth", 16'h0004, {8'h00, stack_depth});
        ret(2'h1, 10'h000);
        chk("inprog", 16'h0001, {14'h0000, inprog_high, inprog_low});
        ret(2'h1, 10'h000);
        mid_instr = 1'b1;
        poll(10'h004, 1'b0, 4'h0);
        mid_instr = 1'b0;
        poll(10'h000, 1'b0, 4'h0);
        wait_ph(4'h4);
        irq_req = 10'h004;
        wait_ph(4'ha);
        irq_req = 10'h000;
        wait_ph(4'h0);
        wr(8'hb7, 8'h00);
        wait_ph(4'h3);
        tick();
        chk("vector_call", 16'h0000, {15'h0000, hardware_vector_call});
        poll(10'h004, 1'b1, 4'h2);
        ret(2'h2, 10'h004);
        chk("inprog_low", 16'h0001, {15'h0000, inprog_low});
        ret(2'h1, 10'h000);
        wr(8'h87, 8'h01);
        chk("halt_idle", 16'h0002, {14'h0000, cpu_halt, periph_disable});
        poll(10'h004, 1'b1, 4'h2);
        chk("cpu_halt", 16'h0000, {15'h0000, cpu_halt});
        rd(8'h87, 8'h00);
        ret(2'h1, 10'h000);
        wr(8'h87, 8'hfc);
        rd(8'h87, 8'hfc);
        chk("power_control_out", 16'h003f, {10'h000, baud_double_first, baud_double_second, lowvolt_reset_disable,
            adc_irq_enable, rx_clock_select_second, tx_clock_select_second});
        wr(8'h87, 8'h03);
        chk("pd_out", 16'h0007, {13'h0000, cpu_halt, sys_clock_stop, periph_disable});
        rd(8'h87, 8'h02);
        wr(8'h87, 8'h00);
        irq_req = 10'h3ff;
        repeat (30) begin
            tick();
            chk("vector_call", 16'h0000, {15'h0000, hardware_vector_call});
        end
        chk("clock_stop", 16'h0001, {15'h0000, sys_clock_stop});
        rd(8'h87, 8'h02);
        irq_req = 10'h000;
        srst = 1'b1;
        repeat (2) tick();
        srst = 1'b0;
        chk("clock_stop", 16'h0000, {15'h0000, sys_clock_stop});
        rd(8'h87, 8'h00);
        close_out();
    end
endmodule : tb_irq_priority_vector_power_ctrl
